/* design/qrw_pkg.sv */
/*
  Shared constants for the quad read / wrap command link: instruction
  codes, field positions, phase lengths, defaults and link clock divider.
  Assumes nothing of its surroundings.
*/
package qrw_pkg;
  // instruction codes
  localparam logic [7:0] CMD_WORD_QREAD = 8'hE7;
  localparam logic [7:0] CMD_QIO_READ = 8'hEB;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_BURST_WRAP = 8'h0C;
  localparam logic [7:0] CMD_SET_WRAP = 8'h77;
  localparam logic [7:0] CMD_SET_PARAM = 8'hC0;
  localparam logic [7:0] CMD_RST_EN = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;
  //////////////////////////////////////////////////////////////////////////
  // field positions
  localparam logic [3:0] CONT_KEY = 4'hA;
  localparam int WRAP_OFF_POS = 4;
  localparam int WRAP_SIZE_LSB = 5;
  localparam int PARAM_DUMMY_LSB = 4;
  localparam int PARAM_WRAP_LSB = 0;
  localparam logic [1:0] DUMMY_CODE_SHORT = 2'h0;
  localparam logic [1:0] DUMMY_CODE_LONG = 2'h3;
  //////////////////////////////////////////////////////////////////////////
  // phase lengths in link clocks
  localparam logic [3:0] CMD_CLKS_SPI = 4'h8;
  localparam logic [3:0] CMD_CLKS_QUAD = 4'h2;
  localparam logic [3:0] ADDR_CLKS = 4'h6;
  localparam logic [3:0] BYTE_CLKS = 4'h2;
  localparam logic [3:0] DUMMY_WORD_READ = 4'h2;
  localparam logic [3:0] DUMMY_QIO_SPI = 4'h4;
  localparam logic [3:0] DUMMY_SHORT = 4'h4;
  localparam logic [3:0] DUMMY_LONG = 4'h8;
  //////////////////////////////////////////////////////////////////////////
  // defaults
  localparam logic WRAP_OFF_DEF = 1'b1;
  localparam logic [1:0] WRAP_SIZE_DEF = 2'h0;
  localparam logic [7:0] WRAP_OFF_SETTING = 8'h10;
  localparam logic [6:0] WRAP_BASE_SPAN = 7'h08;
  // host link clock: half period in reference clocks
  localparam logic [2:0] SCK_HALF = 3'h4;
endpackage

/* design/qrw_link_if.sv */
/*
  Link between host controller and flash device: select, link clock and
  four data lines. Assumes idle lines are pulled high when nobody drives.
*/
`timescale 1ns/10ps
interface qrw_link_if;
  logic cs_n;
  logic sck;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] io;

  // wire level from enables, pull-up when released
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dev_io_oe[i]) begin
        io[i] = dev_io_o[i];
      end else if (host_io_oe[i]) begin
        io[i] = host_io_o[i];
      end else begin
        io[i] = 1'b1;
      end
    end
  end

  modport dev (input cs_n, input sck, input io, output dev_io_o, output dev_io_oe);
  modport host (output cs_n, output sck, output host_io_o, output host_io_oe, input io);
endinterface

/* design/qrw_dev.sv */
/*
  Flash device end: quad read command interpreter with continuous read,
  wrap-around bursts, read parameters and software reset.
  Assumes: runs entirely on the link clock, which the host keeps toggling
  (also while select is high and during srst_in); array data comes back
  combinationally on rd_data_in for rd_addr_out.
*/
// Notes on behaviour
// RULE_01 - word quad read needs quad enable
// RULE_02 - host keeps start address even
// RULE_03 - word read: two dummy clocks then data
// RULE_04 - mode byte follows address; upper nibble used
// RULE_05 - host releases lines before data out
// RULE_06 - mode nibble A skips next instruction byte
// RULE_07 - other nibble restores normal instruction decoding
// RULE_08 - wrap within aligned section until deselect
// RULE_09 - set wrap needs quad enable
// RULE_10 - set wrap: code, 24 dummy, 8 bits
// RULE_11 - bit 4 disables wrap; bits 6:5 size
// RULE_12 - wrap setting applies to later quad reads
// RULE_13 - wrap disabled at power-on
// RULE_14 - host restores wrap off after reset
// RULE_15 - burst wrap read: fast read that wraps
// RULE_16 - parameter command sets dummy and wrap length
// RULE_17 - parameter command rejected in serial mode
// RULE_18 - wrap length kept across mode switch
// RULE_19 - reset defaults: eight bytes, four dummies
// RULE_20 - dummy code 00 four, 11 eight
// RULE_21 - parameter bits 1:0 select wrap length
// RULE_22 - software reset restores all read settings
// RULE_23 - undefined dummy codes keep previous count
`timescale 1ns/10ps
module qrw_dev (
  qrw_link_if.dev link,
  input wire logic srst_in,
  input wire logic quad_enable_flag_in,
  input wire logic quad_command_mode_in,
  input wire logic [7:0] rd_data_in,
  output logic [23:0] rd_addr_out,
  output logic execute_in_place_out,
  output logic wrap_disable_bit_out,
  output logic [1:0] wrap_size_field_out,
  output logic [3:0] dummy_clks_out
);
  typedef enum {
    ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_WRAPB, ST_PARAM, ST_IGN
  } qrw_dst_t;

  qrw_dst_t state_reg;
  qrw_dst_t state_next;
  logic qe_s1_reg, qe_s2_reg, qcm_s1_reg, qcm_s2_reg;
  logic [3:0] cnt_reg;
  logic [3:0] dum_reg;
  logic nib_reg;
  logic [23:0] sh_reg;
  logic [7:0] cmd_reg;
  logic [23:0] addr_reg;
  logic cont_reg;
  logic wrap_off_reg;
  logic [1:0] wrap_size_reg;
  logic [3:0] dummy_reg;
  logic rst_en_reg;
  logic [3:0] out_reg;
  logic [3:0] oe_reg;
  logic [7:0] byte_in;
  logic [3:0] last_cnt;
  logic done;
  logic sw_rst;
  logic wrap_on;
  logic [6:0] span;
  logic [5:0] mask;
  logic [5:0] low_inc;
  logic [23:0] addr_next;
  logic [3:0] mode_dummy;

  //////////////////////////////////////////////////////////////////////////
  // status levels from the other domain
  always_ff @(posedge link.sck) begin
    qe_s1_reg <= quad_enable_flag_in;
    qe_s2_reg <= qe_s1_reg;
    qcm_s1_reg <= quad_command_mode_in;
    qcm_s2_reg <= qcm_s1_reg;
  end

  //////////////////////////////////////////////////////////////////////////
  // phase bookkeeping
  always_comb begin
    if (state_reg == ST_CMD && !qcm_s2_reg) begin
      byte_in = {sh_reg[6:0], link.io[0]};
    end else begin
      byte_in = {sh_reg[3:0], link.io};
    end
    case (state_reg)
      ST_CMD: last_cnt = (qcm_s2_reg ? qrw_pkg::CMD_CLKS_QUAD : qrw_pkg::CMD_CLKS_SPI) - 4'h1;
      ST_ADDR: last_cnt = qrw_pkg::ADDR_CLKS - 4'h1;
      ST_DUMMY: last_cnt = dum_reg - 4'h1;
      default: last_cnt = qrw_pkg::BYTE_CLKS - 4'h1;
    endcase
    done = (cnt_reg == last_cnt);
    sw_rst = (state_reg == ST_CMD) && done && (byte_in == qrw_pkg::CMD_RST) && rst_en_reg;
    // dummy clocks left after the mode byte
    if (cmd_reg == qrw_pkg::CMD_WORD_QREAD) begin
      mode_dummy = qrw_pkg::DUMMY_WORD_READ; // RULE_03
    end else if (qcm_s2_reg) begin
      mode_dummy = dummy_reg - qrw_pkg::BYTE_CLKS; // RULE_16
    end else begin
      mode_dummy = qrw_pkg::DUMMY_QIO_SPI; // RULE_17
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_CMD: begin
        if (done) begin
          state_next = ST_IGN;
          case (byte_in)
            qrw_pkg::CMD_WORD_QREAD: begin
              if (!qcm_s2_reg && qe_s2_reg) state_next = ST_ADDR; // RULE_01
            end
            qrw_pkg::CMD_QIO_READ: begin
              if (qe_s2_reg) state_next = ST_ADDR;
            end
            qrw_pkg::CMD_FAST_READ, qrw_pkg::CMD_BURST_WRAP: begin
              if (qcm_s2_reg) state_next = ST_ADDR; // RULE_15
            end
            qrw_pkg::CMD_SET_WRAP: begin
              if (!qcm_s2_reg && qe_s2_reg) state_next = ST_ADDR; // RULE_09
            end
            qrw_pkg::CMD_SET_PARAM: begin
              if (qcm_s2_reg) state_next = ST_PARAM; // RULE_17
            end
            default: state_next = ST_IGN;
          endcase
        end
      end
      ST_ADDR: begin
        if (done) begin
          if (cmd_reg == qrw_pkg::CMD_SET_WRAP) begin
            state_next = ST_WRAPB; // RULE_10
          end else if (cmd_reg == qrw_pkg::CMD_WORD_QREAD || cmd_reg == qrw_pkg::CMD_QIO_READ) begin
            state_next = ST_MODE; // RULE_04
          end else begin
            state_next = ST_DUMMY;
          end
        end
      end
      ST_MODE: begin
        if (done) state_next = ST_DUMMY;
      end
      ST_DUMMY: begin
        if (done) state_next = ST_DATA; // RULE_03
      end
      ST_WRAPB, ST_PARAM: begin
        if (done) state_next = ST_IGN;
      end
      ST_DATA: state_next = ST_DATA;
      ST_IGN: state_next = ST_IGN;
      default: state_next = ST_IGN;
    endcase
  end

  always_ff @(posedge link.sck) begin
    if (srst_in) begin
      state_reg <= ST_CMD;
      cnt_reg <= 4'h0;
      nib_reg <= 1'b0;
    end else if (link.cs_n) begin
      state_reg <= cont_reg ? ST_ADDR : ST_CMD; // RULE_06 RULE_07
      cnt_reg <= 4'h0;
      nib_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (done || state_reg == ST_DATA) ? 4'h0 : cnt_reg + 4'h1;
      nib_reg <= (state_reg == ST_DATA) ? !nib_reg : 1'b0;
    end
  end

  always_ff @(posedge link.sck) begin
    if (state_reg == ST_CMD && !qcm_s2_reg) begin
      sh_reg <= {sh_reg[22:0], link.io[0]};
    end else begin
      sh_reg <= {sh_reg[19:0], link.io};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // address walk with wrap
  always_comb begin
    wrap_on = (cmd_reg == qrw_pkg::CMD_BURST_WRAP) || // RULE_15
      (!wrap_off_reg && (cmd_reg == qrw_pkg::CMD_WORD_QREAD ||
      cmd_reg == qrw_pkg::CMD_QIO_READ)); // RULE_12
    span = qrw_pkg::WRAP_BASE_SPAN << wrap_size_reg; // RULE_11
    mask = 6'((span - 7'h01));
    low_inc = addr_reg[5:0] + 6'h01;
    if (wrap_on) begin
      addr_next = {addr_reg[23:6], (addr_reg[5:0] & ~mask) | (low_inc & mask)}; // RULE_08
    end else begin
      addr_next = addr_reg + 24'h000001;
    end
  end

  always_ff @(posedge link.sck) begin
    if (srst_in) begin
      cmd_reg <= 8'h00;
      addr_reg <= 24'h000000;
    end else if (!link.cs_n) begin
      if (state_reg == ST_CMD && done) cmd_reg <= byte_in;
      if (state_reg == ST_ADDR && done) addr_reg <= {sh_reg[19:0], link.io};
      if (state_reg == ST_DATA && nib_reg) addr_reg <= addr_next;
    end
  end

  always_ff @(posedge link.sck) begin
    if (srst_in) begin
      dum_reg <= qrw_pkg::DUMMY_SHORT;
    end else if (!link.cs_n) begin
      if (state_reg == ST_ADDR && done) dum_reg <= dummy_reg; // RULE_16
      if (state_reg == ST_MODE && done) dum_reg <= mode_dummy;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // persistent read settings
  always_ff @(posedge link.sck) begin
    if (srst_in || sw_rst) begin
      cont_reg <= 1'b0; // RULE_22
      wrap_off_reg <= qrw_pkg::WRAP_OFF_DEF; // RULE_13
      wrap_size_reg <= qrw_pkg::WRAP_SIZE_DEF; // RULE_19
      dummy_reg <= qrw_pkg::DUMMY_SHORT;
      rst_en_reg <= 1'b0;
    end else if (!link.cs_n) begin
      if (state_reg == ST_CMD && done) rst_en_reg <= (byte_in == qrw_pkg::CMD_RST_EN);
      if (state_reg == ST_MODE && done) cont_reg <= (byte_in[7:4] == qrw_pkg::CONT_KEY); // RULE_06
      if (state_reg == ST_WRAPB && done) begin
        wrap_off_reg <= byte_in[qrw_pkg::WRAP_OFF_POS]; // RULE_11
        wrap_size_reg <= byte_in[qrw_pkg::WRAP_SIZE_LSB +: 2]; // RULE_18
      end
      if (state_reg == ST_PARAM && done) begin
        wrap_size_reg <= byte_in[qrw_pkg::PARAM_WRAP_LSB +: 2]; // RULE_21
        case (byte_in[qrw_pkg::PARAM_DUMMY_LSB +: 2])
          qrw_pkg::DUMMY_CODE_SHORT: dummy_reg <= qrw_pkg::DUMMY_SHORT; // RULE_20
          qrw_pkg::DUMMY_CODE_LONG: dummy_reg <= qrw_pkg::DUMMY_LONG;
          default: dummy_reg <= dummy_reg; // RULE_23
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output nibbles change on the falling link clock
  always_ff @(negedge link.sck) begin
    if (srst_in) begin
      out_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else begin
      out_reg <= nib_reg ? rd_data_in[3:0] : rd_data_in[7:4];
      oe_reg <= (state_reg == ST_DATA && !link.cs_n) ? 4'hF : 4'h0;
    end
  end

  // release at once when deselected
  assign link.dev_io_oe = oe_reg & {4{!link.cs_n}};
  assign link.dev_io_o = out_reg;
  assign rd_addr_out = addr_reg;
  assign execute_in_place_out = cont_reg;
  assign wrap_disable_bit_out = wrap_off_reg;
  assign wrap_size_field_out = wrap_size_reg;
  assign dummy_clks_out = dummy_reg;
endmodule // qrw_dev

/* design/qrw_host.sv */
/*
  Host controller end: runs one command frame per request, makes the link
  clock from ref_clk_in and collects read bytes.
  Assumes the requester knows the dummy count the device expects.
*/
`timescale 1ns/10ps
module qrw_host (
  qrw_link_if.host link,
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [7:0] req_cmd_in,
  input wire logic [23:0] req_addr_in,
  input wire logic [7:0] req_arg_in,
  input wire logic req_quad_cmd_in,
  input wire logic req_skip_cmd_in,
  input wire logic [3:0] req_dummy_in,
  input wire logic [7:0] req_len_in,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic done_out
);
  typedef enum {H_IDLE, H_CMD, H_ADDR, H_ARG, H_DUMMY, H_DATA, H_END} qrw_hst_t;

  qrw_hst_t state_reg;
  qrw_hst_t post;
  logic [2:0] div_reg;
  logic sck_reg, rise_ev, fall_ev;
  logic [3:0] io_s1_reg, io_s2_reg, hi_reg;
  logic [39:0] sr_reg;
  logic [8:0] cnt_reg;
  logic [8:0] last_cnt;
  logic [7:0] cmd_reg, len_reg;
  logic [3:0] dum_reg;
  logic quad_reg, boot_reg;
  logic has_addr, has_arg, reads;
  logic cs_n_reg;
  logic [3:0] io_o_reg, oe_reg;
  logic [23:0] addr_eff;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      div_reg <= 3'h0;
      sck_reg <= 1'b0;
    end else if (div_reg == qrw_pkg::SCK_HALF - 3'h1) begin
      div_reg <= 3'h0;
      sck_reg <= !sck_reg;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    io_s1_reg <= link.io;
    io_s2_reg <= io_s1_reg;
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    rise_ev = (div_reg == qrw_pkg::SCK_HALF - 3'h1) && !sck_reg;
    fall_ev = (div_reg == qrw_pkg::SCK_HALF - 3'h1) && sck_reg;
    has_addr = cmd_reg inside {qrw_pkg::CMD_WORD_QREAD, qrw_pkg::CMD_QIO_READ,
      qrw_pkg::CMD_FAST_READ, qrw_pkg::CMD_BURST_WRAP, qrw_pkg::CMD_SET_WRAP};
    has_arg = cmd_reg inside {qrw_pkg::CMD_WORD_QREAD, qrw_pkg::CMD_QIO_READ,
      qrw_pkg::CMD_SET_WRAP, qrw_pkg::CMD_SET_PARAM};
    reads = cmd_reg inside {qrw_pkg::CMD_WORD_QREAD, qrw_pkg::CMD_QIO_READ,
      qrw_pkg::CMD_FAST_READ, qrw_pkg::CMD_BURST_WRAP};
    if (reads && dum_reg != 4'h0) begin
      post = H_DUMMY;
    end else if (reads && len_reg != 8'h00) begin
      post = H_DATA;
    end else begin
      post = H_END;
    end
    case (state_reg)
      H_CMD: last_cnt = {5'h00, (quad_reg ? qrw_pkg::CMD_CLKS_QUAD : qrw_pkg::CMD_CLKS_SPI)} - 9'h001;
      H_ADDR: last_cnt = {5'h00, qrw_pkg::ADDR_CLKS} - 9'h001;
      H_DUMMY: last_cnt = {5'h00, dum_reg} - 9'h001;
      H_DATA: last_cnt = {len_reg, 1'b0} - 9'h001;
      default: last_cnt = {5'h00, qrw_pkg::BYTE_CLKS} - 9'h001;
    endcase
    // word read starts on an even address
    addr_eff = req_addr_in;
    if (req_cmd_in == qrw_pkg::CMD_WORD_QREAD) addr_eff[0] = 1'b0; // RULE_02
  end

  assign req_ready_out = (state_reg == H_IDLE) && !boot_reg && rise_ev;

  //////////////////////////////////////////////////////////////////////////
  // frame sequencing on the rising link clock
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_reg <= H_IDLE;
      boot_reg <= 1'b1;
      cnt_reg <= 9'h000;
      cmd_reg <= 8'h00;
      len_reg <= 8'h00;
      dum_reg <= 4'h0;
      quad_reg <= 1'b0;
      sr_reg <= 40'h0000000000;
    end else if (rise_ev) begin
      cnt_reg <= cnt_reg + 9'h001;
      if (state_reg == H_CMD && !quad_reg) begin
        sr_reg <= {sr_reg[38:0], 1'b0};
      end else begin
        sr_reg <= {sr_reg[35:0], 4'h0};
      end
      case (state_reg)
        H_IDLE: begin
          cnt_reg <= 9'h000;
          if (boot_reg) begin
            // put wrapping back off after our own reset
            boot_reg <= 1'b0; // RULE_14
            cmd_reg <= qrw_pkg::CMD_SET_WRAP;
            quad_reg <= 1'b0;
            len_reg <= 8'h00;
            dum_reg <= 4'h0;
            sr_reg <= {qrw_pkg::CMD_SET_WRAP, 24'h000000, qrw_pkg::WRAP_OFF_SETTING};
            state_reg <= H_CMD;
          end else if (req_valid_in) begin
            cmd_reg <= req_cmd_in;
            quad_reg <= req_quad_cmd_in;
            len_reg <= req_len_in;
            dum_reg <= req_dummy_in;
            if (req_cmd_in == qrw_pkg::CMD_SET_PARAM) begin
              sr_reg <= {req_cmd_in, req_arg_in, 24'h000000};
            end else if (req_skip_cmd_in) begin
              sr_reg <= {addr_eff, req_arg_in, 8'h00};
            end else begin
              sr_reg <= {req_cmd_in, addr_eff, req_arg_in}; // RULE_04 RULE_10
            end
            state_reg <= req_skip_cmd_in ? H_ADDR : H_CMD;
          end
        end
        H_END: begin
          state_reg <= H_IDLE;
        end
        default: begin
          if (cnt_reg == last_cnt) begin
            cnt_reg <= 9'h000;
            case (state_reg)
              H_CMD: state_reg <= has_addr ? H_ADDR : (has_arg ? H_ARG : post);
              H_ADDR: state_reg <= has_arg ? H_ARG : post;
              H_ARG: state_reg <= post;
              H_DUMMY: state_reg <= (len_reg != 8'h00) ? H_DATA : H_END;
              default: state_reg <= H_END;
            endcase
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // line drive on the falling link clock
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cs_n_reg <= 1'b1;
      io_o_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else if (fall_ev) begin
      cs_n_reg <= (state_reg == H_IDLE) || (state_reg == H_END);
      if (state_reg == H_CMD && !quad_reg) begin
        io_o_reg <= {3'h0, sr_reg[39]};
        oe_reg <= 4'h1;
      end else begin
        io_o_reg <= sr_reg[39:36];
        // released through dummy and data
        oe_reg <= (state_reg inside {H_CMD, H_ADDR, H_ARG}) ? 4'hF : 4'h0; // RULE_05
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data capture
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      hi_reg <= 4'h0;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      done_out <= rise_ev && (state_reg == H_END);
      if (rise_ev && state_reg == H_DATA) begin
        if (!cnt_reg[0]) begin
          hi_reg <= io_s2_reg;
        end else begin
          rd_data_out <= {hi_reg, io_s2_reg};
          rd_valid_out <= 1'b1;
        end
      end
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.sck = sck_reg;
  assign link.host_io_o = io_o_reg;
  assign link.host_io_oe = oe_reg;
endmodule // qrw_host

/* dv/qrw_sva.sv */
/*
  Link checker: relations between select, the data line enables and the
  resolved data lines. Assumes it is instantiated beside the link interface
  and clocked by the link clock with the device reset.
*/
`timescale 1ns/10ps
module qrw_sva (
  input wire logic sck,
  input wire logic srst_in,
  input wire logic cs_n,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge sck);
  endclocking
  default disable iff (srst_in);
  //////////////////////////////////////////////////////////////////////////
  oe_exclusive_a: assert property ((dev_io_oe & host_io_oe) == 4'h0)
    else $error("device and host drive the data lines together");
  deselect_quiet_a: assert property (cs_n |-> dev_io_oe == 4'h0)
    else $error("device drives while deselected");
  release_first_a: assert property ($rose(|dev_io_oe) |-> $past(host_io_oe) == 4'h0)
    else $error("host still drove just before read data");
  quad_width_a: assert property (|dev_io_oe |-> dev_io_oe == 4'hF)
    else $error("read data not on all four lines");
  burst_until_cs_a: assert property ($fell(|dev_io_oe) |-> cs_n)
    else $error("read data stopped while still selected");
  host_in_frame_a: assert property (|host_io_oe |-> !cs_n)
    else $error("host drives outside a frame");
  no_early_drive_a: assert property ($fell(cs_n) |-> (dev_io_oe == 4'h0) [*8])
    else $error("device drove during the address phase");
  float_high_a: assert property ((dev_io_oe | host_io_oe) == 4'h0 |-> io == 4'hF)
    else $error("released lines not pulled high");
endmodule // qrw_sva

/* dv/quad_read_wrap_control_bench.sv */
/*
  Bench joining host and device ends across the link; table of command
  frames with expected bytes and settings, then reset handling.
  Assumes the host makes the link clock; array byte is address xor 5Ah.
*/
`timescale 1ns/10ps
module quad_read_wrap_control_bench;
  typedef struct packed {
    logic [7:0] cmd; logic [7:0] addr; logic [7:0] arg; logic [3:0] mode;
    logic [3:0] dummy; logic [3:0] len; logic [7:0] span; logic refused; logic [7:0] st;
  } qrw_row_t;
  logic ref_clk_in = 1'h0;
  logic srst_in = 1'h1;
  logic dev_srst = 1'h1;
  logic qe = 1'h1;
  logic quad_command_mode = 1'h0;
  logic req_valid = 1'h0;
  logic req_ready, req_quad, req_skip, rd_valid, done, execute_in_place, woff;
  logic [7:0] req_cmd, req_arg, req_len, rd_data;
  logic [23:0] req_addr, rd_addr;
  logic [3:0] req_dummy, dclks;
  logic [1:0] wsize;
  logic [7:0] got_q[$];
  int bad_count = 0;
  int n_checks = 0;
  // mode bits: quad instruction, skip instruction, quad mode, quad enable
  qrw_row_t rows[21] = '{
    '{8'hE7, 8'h06, 8'h00, 4'h1, 4'h2, 4'h4, 8'h00, 1'h0, 8'h44},
    '{8'h77, 8'h00, 8'h00, 4'h1, 4'h0, 4'h0, 8'h00, 1'h0, 8'h04},
    '{8'hE7, 8'h06, 8'h00, 4'h1, 4'h2, 4'h4, 8'h08, 1'h0, 8'h04},
    '{8'h77, 8'h00, 8'hAF, 4'h1, 4'h0, 4'h0, 8'h00, 1'h0, 8'h14},
    '{8'hE7, 8'h0E, 8'hA5, 4'h1, 4'h2, 4'h4, 8'h10, 1'h0, 8'h94},
    '{8'hE7, 8'h1E, 8'h00, 4'h5, 4'h2, 4'h3, 8'h10, 1'h0, 8'h14},
    '{8'hE7, 8'h20, 8'h00, 4'h1, 4'h2, 4'h2, 8'h10, 1'h0, 8'h14},
    '{8'hE7, 8'h00, 8'h00, 4'h0, 4'h2, 4'h2, 8'h00, 1'h1, 8'h14},
    '{8'h77, 8'h00, 8'h10, 4'h0, 4'h0, 4'h0, 8'h00, 1'h0, 8'h14},
    '{8'h77, 8'h00, 8'h70, 4'h1, 4'h0, 4'h0, 8'h00, 1'h0, 8'h74},
    '{8'h0C, 8'h3E, 8'h00, 4'hB, 4'h4, 4'h3, 8'h40, 1'h0, 8'h74},
    '{8'hC0, 8'h00, 8'h31, 4'hB, 4'h0, 4'h0, 8'h00, 1'h0, 8'h58},
    '{8'hC0, 8'h00, 8'h11, 4'hB, 4'h0, 4'h0, 8'h00, 1'h0, 8'h58},
    '{8'h0C, 8'h0E, 8'h00, 4'hB, 4'h8, 4'h3, 8'h10, 1'h0, 8'h58},
    '{8'h0B, 8'h0E, 8'h00, 4'hB, 4'h8, 4'h3, 8'h00, 1'h0, 8'h58},
    '{8'hEB, 8'h0E, 8'h00, 4'hB, 4'h6, 4'h3, 8'h00, 1'h0, 8'h58},
    '{8'h66, 8'h00, 8'h00, 4'h1, 4'h0, 4'h0, 8'h00, 1'h0, 8'h58},
    '{8'hC0, 8'h00, 8'h00, 4'h1, 4'h0, 4'h0, 8'h00, 1'h0, 8'h58},
    '{8'h99, 8'h00, 8'h00, 4'h1, 4'h0, 4'h0, 8'h00, 1'h0, 8'h58},
    '{8'h66, 8'h00, 8'h00, 4'h1, 4'h0, 4'h0, 8'h00, 1'h0, 8'h58},
    '{8'h99, 8'h00, 8'h00, 4'h1, 4'h0, 4'h0, 8'h00, 1'h0, 8'h44}
  };
  //////////////////////////////////////////////////////////////////////////
  qrw_link_if qrw_link_if_inst ();
  qrw_host qrw_host_inst (.link(qrw_link_if_inst), .ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_cmd_in(req_cmd),
    .req_addr_in(req_addr), .req_arg_in(req_arg), .req_quad_cmd_in(req_quad),
    .req_skip_cmd_in(req_skip), .req_dummy_in(req_dummy), .req_len_in(req_len),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .done_out(done));
  qrw_dev qrw_dev_inst (.link(qrw_link_if_inst), .srst_in(dev_srst), .quad_enable_flag_in(qe),
    .quad_command_mode_in(quad_command_mode), .rd_data_in(rd_addr[7:0] ^ 8'h5A), .rd_addr_out(rd_addr),
    .execute_in_place_out(execute_in_place), .wrap_disable_bit_out(woff), .wrap_size_field_out(wsize),
    .dummy_clks_out(dclks));
  qrw_sva qrw_sva_inst (.sck(qrw_link_if_inst.sck), .srst_in(dev_srst),
    .cs_n(qrw_link_if_inst.cs_n), .dev_io_o(qrw_link_if_inst.dev_io_o),
    .dev_io_oe(qrw_link_if_inst.dev_io_oe), .host_io_o(qrw_link_if_inst.host_io_o),
    .host_io_oe(qrw_link_if_inst.host_io_oe), .io(qrw_link_if_inst.io));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    if (rd_valid === 1'h1) got_q.push_back(rd_data);
  end
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_state(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch state t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // for_done 0 waits for ready, 1 for the frame end; running out counts as a mismatch
  task automatic wait_for(input bit for_done);
    int i;
    i = 0;
    while ((for_done ? done : req_ready) !== 1'h1 && i < 3000) begin
      @(negedge ref_clk_in);
      i++;
    end
    if (i >= 3000) begin
      bad_count++;
      $display("mismatch t=%0t wait timed out got=%h exp=%h", $time, 1'h0, 1'h1);
    end
  endtask
  task automatic run_row(input qrw_row_t r);
    logic [7:0] ea;
    logic [7:0] sa;
    sa = (r.cmd == 8'hE7) ? (r.addr & 8'hFE) : r.addr;
    qe = r.mode[0];
    quad_command_mode = r.mode[1];
    repeat (24) @(negedge ref_clk_in);
    got_q.delete();
    req_cmd = r.cmd;
    req_addr = {16'h0000, r.addr};
    req_arg = r.arg;
    req_quad = r.mode[3];
    req_skip = r.mode[2];
    req_dummy = r.dummy;
    req_len = {4'h0, r.len};
    req_valid = 1'h1;
    wait_for(1'b0);
    @(negedge ref_clk_in);
    req_valid = 1'h0;
    wait_for(1'b1);
    repeat (24) @(negedge ref_clk_in);
    cmp_byte(8'(got_q.size()), {4'h0, r.len});
    for (int i = 0; i < got_q.size() && i < r.len; i++) begin
      if (r.span == 8'h00) ea = sa + 8'(i);
      else ea = (sa & ~(r.span - 8'h01)) | ((sa + 8'(i)) & (r.span - 8'h01));
      cmp_byte(got_q[i], r.refused ? 8'hFF : ea ^ 8'h5A);
    end
    cmp_state({execute_in_place, woff, wsize, dclks}, r.st);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {req_cmd, req_arg, req_len, req_addr, req_dummy, req_quad, req_skip} = '0;
    repeat (3) @(negedge ref_clk_in);
    srst_in = 1'h0;
    wait_for(1'b0);
    dev_srst = 1'h0;
    repeat (24) @(negedge ref_clk_in);
    cmp_state({execute_in_place, woff, wsize, dclks}, 8'h44);
    foreach (rows[k]) run_row(rows[k]);
    // odd start for the word read
    run_row('{8'hE7, 8'h07, 8'h00, 4'h1, 4'h2, 4'h2, 8'h00, 1'h0, 8'h44});
    // host-only reset with wrapping on: host must switch it off again
    run_row(rows[1]);
    srst_in = 1'h1;
    repeat (3) @(negedge ref_clk_in);
    srst_in = 1'h0;
    wait_for(1'b0);
    repeat (24) @(negedge ref_clk_in);
    cmp_state({execute_in_place, woff, wsize, dclks}, 8'h44);
    // device reset in mid-run after a size change
    run_row(rows[9]);
    dev_srst = 1'h1;
    repeat (24) @(negedge ref_clk_in);
    dev_srst = 1'h0;
    repeat (24) @(negedge ref_clk_in);
    cmp_state({execute_in_place, woff, wsize, dclks}, 8'h44);
    run_row(rows[0]);
    summarize();
  end
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    bad_count++;
    summarize();
  end
endmodule // quad_read_wrap_control_bench
